/* bench/ddr2_ctrl_model.sv */
`timescale 1ns/1ps
`include "ddr2_cmd_consts.vh"
// ------------------------------
// controller side of the command bus
// ------------------------------
// pin to decode takes three edges through the enable synchroniser
module ddr2_ctrl_model #(parameter SYNC_LAT = 3) (
  input wire clk_sys, // device clock
  output logic cke, output logic cs_n, // enable, select
  output logic [2:0] cmd, // ras_n, cas_n, we_n
  output logic [2:0] ba, output logic [13:0] addr, // bank, address
  output logic odt, output logic dm // termination, mask
);
  // termination held at a defined level from time zero
  initial begin
    cke = 1'b0;
    cs_n = 1'b1;
    cmd = `CMD_NOP;
    ba = 3'h0;
    addr = 14'h0000;
    odt = 1'b0;
    dm = 1'b0;
  end
  // idle clocks: address toggles so a stale value is never mistaken for a held one
  task automatic nop(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      cs_n = 1'b0;
      cmd = `CMD_NOP;
      addr = ~addr;
    end
  endtask
  // one specified command for one clock, then nop
  task automatic send(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a,
    input logic m);
    @(negedge clk_sys);
    cs_n = 1'b0;
    cmd = c;
    ba = b;
    addr = a;
    dm = m;
    nop(1);
  endtask
  // enable edge; c lands on the clock where the synchronised edge is decoded
  task automatic edge_to(input logic lvl, input logic [2:0] c);
    nop(3);
    cke = lvl;
    nop(SYNC_LAT - 1);
    send(c, ba, addr, dm);
    nop(3);
  endtask
  // exit edge carried by a deselect; the strobes behind it are don't-care
  task automatic edge_desel();
    nop(3);
    cke = 1'b1;
    nop(SYNC_LAT - 1);
    @(negedge clk_sys);
    cs_n = 1'b1;
    cmd = `CMD_RD;
    nop(3);
  endtask
  // forced reset: enable drops between edges with a read just behind it
  task automatic drop_under_read();
    @(negedge clk_sys);
    #3 cke = 1'b0;
    send(`CMD_RD, ba, addr, dm);
    nop(3);
  endtask
endmodule // ddr2_ctrl_model

/* bench/ddr2_decoder_props.sv */
`timescale 1ns/1ps
`include "ddr2_cmd_consts.vh"
// ------------------------------
// decoder port checks
// ------------------------------
module ddr2_decoder_props #(parameter ADDR_W = 14) (
  input wire clk_sys, input wire rstn, // clock, reset
  input wire cs_n, input wire ras_n, input wire cas_n, input wire we_n, // strobes
  input wire [ADDR_W-1:0] addr, input wire dm, // address, mask
  input wire [3:0] cmd_op, input wire cmd_valid, input wire cmd_all_banks, // decode
  input wire wr_beat_en, input wire burst_busy, input wire odt_en, // data path
  input wire active_pd, input wire precharge_pd, input wire self_refresh, // states
  input wire ready, input wire contents_lost // init state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire [3:0] strb = {cs_n, ras_n, cas_n, we_n};
  // a burst decode is busy on its own clock and the next one, and nothing may cut that
  sequence s_rw;
    cmd_valid && (cmd_op == `OP_RD || cmd_op == `OP_RDA || cmd_op == `OP_WR || cmd_op == `OP_WRA);
  endsequence
  sequence s_busy2;
    burst_busy ##1 burst_busy;
  endsequence
  a_read_decode: assert property (cmd_valid && cmd_op == `OP_RD |-> $past(strb) == 4'b0101)
    else $error("read decoded from other strobes");
  a_burst_len: assert property (s_rw |-> s_busy2)
    else $error("burst shorter than two clocks");
  a_all_banks: assert property (cmd_all_banks |-> cmd_op == `OP_PREALL &&
    $past(addr[10]) && $past(strb) == 4'b0010) else $error("all bank precharge wrong");
  a_deselect_quiet: assert property (cmd_valid && $past(cs_n) |->
    cmd_op == `OP_PD_IN || cmd_op == `OP_EXIT || cmd_op == `OP_ILLEGAL)
    else $error("deselect decoded as command");
  a_mask_write: assert property (wr_beat_en == ($past(burst_busy) && !$past(dm)))
    else $error("data beat mask wrong");
  a_sref_no_odt: assert property (self_refresh |-> !odt_en)
    else $error("termination on in self refresh");
  a_pd_states: assert property ((active_pd || precharge_pd || self_refresh) |->
    !ready && !(active_pd && precharge_pd)) else $error("power state clash");
  a_lost_unready: assert property ($rose(contents_lost) |-> !ready ##1 !ready)
    else $error("ready while contents lost");
endmodule // ddr2_decoder_props
bind ddr2_command_cke_decoder ddr2_decoder_props #(.ADDR_W(ADDR_W)) u_props (
  .clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .addr(addr), .dm(dm), .cmd_op(cmd_op), .cmd_valid(cmd_valid), .cmd_all_banks(cmd_all_banks),
  .wr_beat_en(wr_beat_en), .burst_busy(burst_busy), .odt_en(odt_en), .active_pd(active_pd),
  .precharge_pd(precharge_pd), .self_refresh(self_refresh), .ready(ready),
  .contents_lost(contents_lost));

/* bench/tb.sv */
`timescale 1ns/1ps
`include "ddr2_cmd_consts.vh"
module tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic init_done = 1'b0;
  wire cke, cs_n, odt, dm, cmd_valid, cmd_auto_pre, cmd_all_banks, wr_beat_en, burst_busy;
  wire active_pd, precharge_pd, self_refresh, odt_en, ready, contents_lost, illegal_seen;
  wire [2:0] cmd, ba, cmd_bank;
  wire [13:0] addr, cmd_addr;
  wire [3:0] cmd_op;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [16:0] rnd = 17'h1_00b2;
  logic [2:0] codes [10] = '{`CMD_MRS, `CMD_REF, `CMD_ACT, `CMD_WR, `CMD_WR, `CMD_RD,
    `CMD_RD, `CMD_PRE, `CMD_PRE, `CMD_ACT};
  // free running, so clocks stay stable across every enable drop
  always #12.5 clk_sys = ~clk_sys;
  ddr2_ctrl_model ctl (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba),
    .addr(addr), .odt(odt), .dm(dm));
  ddr2_command_cke_decoder uut (.clk_sys(clk_sys), .rstn(rstn), .cke(cke), .cs_n(cs_n),
    .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .ba(ba), .addr(addr), .odt(odt), .dm(dm),
    .init_done(init_done), .cmd_op(cmd_op), .cmd_valid(cmd_valid), .cmd_bank(cmd_bank),
    .cmd_addr(cmd_addr), .cmd_auto_pre(cmd_auto_pre), .cmd_all_banks(cmd_all_banks),
    .wr_beat_en(wr_beat_en), .burst_busy(burst_busy), .active_pd(active_pd),
    .precharge_pd(precharge_pd), .self_refresh(self_refresh), .odt_en(odt_en), .ready(ready),
    .contents_lost(contents_lost), .illegal_seen(illegal_seen));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // decode id expected from strobe code and the precharge/auto bit
  function automatic logic [3:0] exp_op(input logic [2:0] c, input logic ap);
    case (c)
      `CMD_MRS: return `OP_MRS;
      `CMD_REF: return `OP_REF;
      `CMD_PRE: return ap ? `OP_PREALL : `OP_PRE;
      `CMD_ACT: return `OP_ACT;
      `CMD_WR: return ap ? `OP_WRA : `OP_WR;
      default: return ap ? `OP_RDA : `OP_RD;
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait for one state flag; giving up ends the run
  task automatic wait_flag(input int sel);
    logic [4:0] f;
    f = 5'h00;
    for (int i = 0; i < 60 && !f[sel]; i++) begin
      @(negedge clk_sys);
      f = {contents_lost, self_refresh, precharge_pd, active_pd, ready};
    end
    check("state flag", 16'h0001, {15'h0000, f[sel]});
    if (!f[sel])
      print_verdict();
  endtask
  // one command with random bank, address and mask, then compare the decode that answers it
  task automatic issue(input logic [2:0] c, input logic ap);
    logic [13:0] a;
    rnd = lfsr(rnd);
    a = {rnd[13:11], ap, rnd[9:0]};
    ctl.send(c, rnd[16:14], a, rnd[4]);
    for (int i = 0; i < 4 && cmd_valid !== 1'b1; i++) @(negedge clk_sys);
    check("cmd_valid", 16'h0001, cmd_valid);
    check("cmd_op", exp_op(c, ap), cmd_op);
    check("cmd_bank", rnd[16:14], cmd_bank);
    check("cmd_addr", a, cmd_addr);
    check("cmd_auto_pre", {15'h0000, ap && (c == `CMD_WR || c == `CMD_RD)}, cmd_auto_pre);
    check("cmd_all_banks", {15'h0000, ap && c == `CMD_PRE}, cmd_all_banks);
    check("burst_busy", {15'h0000, c == `CMD_WR || c == `CMD_RD}, burst_busy);
    // no decode within the bound ends the run
    if (cmd_valid !== 1'b1)
      print_verdict();
    ctl.nop(3);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    ctl.edge_to(1'b1, `CMD_NOP);
    init_done = 1'b1;
    wait_flag(0);
    for (int k = 0; k < 10; k++) issue(codes[k], k[0]);
    check("illegal_seen", 16'h0000, illegal_seen);
    ctl.edge_to(1'b0, `CMD_NOP);
    wait_flag(1);
    check("ready", 16'h0000, ready);
    ctl.edge_to(1'b1, `CMD_NOP);
    check("active_pd", 16'h0000, active_pd);
    issue(`CMD_PRE, 1'b1);
    ctl.edge_to(1'b0, `CMD_NOP);
    wait_flag(2);
    ctl.edge_desel();
    check("precharge_pd", 16'h0000, precharge_pd);
    check("ready", 16'h0001, ready);
    ctl.odt = 1'b1;
    ctl.nop(2);
    check("odt_en", 16'h0001, odt_en);
    ctl.edge_to(1'b0, `CMD_REF);
    wait_flag(3);
    check("odt_en", 16'h0000, odt_en);
    ctl.edge_to(1'b1, `CMD_NOP);
    ctl.odt = 1'b0;
    ctl.nop(200);
    init_done = 1'b0;
    ctl.drop_under_read();
    wait_flag(4);
    check("ready", 16'h0000, ready);
    check("illegal_seen", 16'h0001, illegal_seen);
    ctl.edge_to(1'b1, `CMD_NOP);
    init_done = 1'b1;
    wait_flag(0);
    check("illegal_seen", 16'h0000, illegal_seen);
    check("contents_lost", 16'h0000, contents_lost);
    print_verdict();
  end
endmodule // tb

/* core/bank_state_mem.v */
`timescale 1ns/1ps
`include "ddr2_cmd_consts.vh"
// ------------------------------------------------------------
// per-bank open flags, registered read of the any-open summary
// ------------------------------------------------------------
module bank_state_mem #(
  parameter BANKS = 8,
  parameter BA_W = 3
) (
  input wire clk_sys, // system clock
  input wire rstn, // async reset, active low
  input wire clr_all, // close every bank
  input wire set_en, // open the addressed bank
  input wire clr_en, // close the addressed bank
  input wire [BA_W-1:0] bank, // bank address
  output reg any_open // some bank holds an open row
);
  reg [BANKS-1:0] open_row;
  genvar g;
  // one flag per bank; clear of all wins over a set in the same edge
  generate
    for (g = 0; g < BANKS; g = g + 1) begin : g_bank
      // bank index at address width, so the compare is width-clean
      localparam [BA_W-1:0] IDX = g;
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          open_row[g] <= 1'b0;
        end else if (clr_all || (clr_en && bank == IDX)) begin
          open_row[g] <= 1'b0;
        end else if (set_en && bank == IDX) begin
          open_row[g] <= 1'b1;
        end
      end
    end
  endgenerate
  // registered summary, so the top sees the state before each edge
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      any_open <= 1'b0;
    end else begin
      any_open <= |open_row;
    end
  end
endmodule // bank_state_mem

/* core/ddr2_command_cke_decoder.v */
`timescale 1ns/1ps
`include "ddr2_cmd_consts.vh"
module ddr2_command_cke_decoder #(
  parameter BA_W = 3,
  parameter ADDR_W = 14,
  parameter AP_BIT = 10,
  parameter BANKS = 8
) (
  input wire clk_sys, // device clock, 40 MHz
  input wire rstn, // async reset, active low
  input wire cke, // clock enable pin
  input wire cs_n, // chip select, low active
  input wire ras_n, // row strobe, low active
  input wire cas_n, // column strobe, low active
  input wire we_n, // write enable, low active
  input wire [BA_W-1:0] ba, // bank address
  input wire [ADDR_W-1:0] addr, // address / op code
  input wire odt, // termination request
  input wire dm, // write data mask
  input wire init_done, // initialization sequence finished
  output reg [3:0] cmd_op, // decoded command id
  output reg cmd_valid, // one-cycle pulse per command
  output reg [BA_W-1:0] cmd_bank, // bank or mode register select
  output reg [ADDR_W-1:0] cmd_addr, // row, column or op code
  output reg cmd_auto_pre, // read/write with autoprecharge
  output reg cmd_all_banks, // precharge of every bank
  output reg wr_beat_en, // current data beat is written
  output reg burst_busy, // read or write burst running
  output reg active_pd, // active power-down state
  output reg precharge_pd, // precharge power-down state
  output reg self_refresh, // self refresh state
  output reg odt_en, // termination effective
  output reg ready, // normal operation allowed
  output reg contents_lost, // array contents not guaranteed
  output reg illegal_seen // unspecified operation seen
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_UNINIT = 5'h01;
  localparam ST_RUN = 5'h02;
  localparam ST_APD = 5'h04;
  localparam ST_PPD = 5'h08;
  localparam ST_SREF = 5'h10;

  // cke comes from a pin: three stages, change taken when 2 and 3 agree
  reg cke_s1, cke_s2, cke_s3, cke_q;
  reg [4:0] state, next_state;
  reg [3:0] burst_cnt;
  reg [3:0] op;
  wire any_open;
  wire [2:0] rcw = {ras_n, cas_n, we_n};
  wire cke_prev = cke_q;
  wire cke_now = (cke_s2 == cke_s3) ? cke_s3 : cke_q;

  // decode of a command from strobe levels, used in ST_UNINIT and ST_RUN while enable stays high
  function [3:0] decode_cmd;
    input csn;
    input [2:0] c;
    input ap;
    begin
      if (csn) begin
        decode_cmd = `OP_NONE;
      end else begin
        case (c)
          `CMD_MRS: decode_cmd = `OP_MRS;
          `CMD_REF: decode_cmd = `OP_REF;
          `CMD_PRE: decode_cmd = ap ? `OP_PREALL : `OP_PRE;
          `CMD_ACT: decode_cmd = `OP_ACT;
          `CMD_WR: decode_cmd = ap ? `OP_WRA : `OP_WR;
          `CMD_RD: decode_cmd = ap ? `OP_RDA : `OP_RD;
          `CMD_NOP: decode_cmd = `OP_NONE;
          default: decode_cmd = `OP_ILLEGAL;
        endcase
      end
    end
  endfunction

  function is_nop;
    input csn;
    input [2:0] c;
    begin
      is_nop = csn || (c == `CMD_NOP);
    end
  endfunction

  // ------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cke_s1 <= 1'b0;
      cke_s2 <= 1'b0;
      cke_s3 <= 1'b0;
      cke_q <= 1'b0;
    end else begin
      cke_s1 <= cke;
      cke_s2 <= cke_s1;
      cke_s3 <= cke_s2;
      cke_q <= cke_now;
    end
  end

  // ------------------------------------------------------------
  // command and enable transition decode
  // ------------------------------------------------------------
  // odt is not an input here on purpose, it never alters decoding
  always @* begin
    op = `OP_NONE;
    next_state = state;
    case (state)
      ST_UNINIT: begin
        // after reset or a drop, only init completion re-enables use
        if (init_done && cke_now) next_state = ST_RUN;
        if (cke_prev && cke_now) op = decode_cmd(cs_n, rcw, addr[AP_BIT]);
      end
      ST_RUN: begin
        if (cke_prev && cke_now) begin
          op = decode_cmd(cs_n, rcw, addr[AP_BIT]);
          // nop never cuts a running burst; new bursts while busy are decoded as illegal
          if (burst_busy && (op == `OP_RD || op == `OP_RDA ||
              op == `OP_WR || op == `OP_WRA)) op = `OP_ILLEGAL;
        end else if (cke_prev && !cke_now) begin
          if (!cs_n && rcw == `CMD_REF && !any_open && !burst_busy) begin
            op = `OP_SREF_IN;
            next_state = ST_SREF;
          end else if (is_nop(cs_n, rcw) && !burst_busy) begin
            op = `OP_PD_IN;
            next_state = any_open ? ST_APD : ST_PPD;
          end else begin
            op = `OP_ILLEGAL;
            next_state = ST_UNINIT;
          end
        end
      end
      ST_APD, ST_PPD, ST_SREF: begin
        // low enable maintains the state; rising with nop exits
        if (cke_now) begin
          if (is_nop(cs_n, rcw)) begin
            op = `OP_EXIT;
            next_state = ST_RUN;
          end else begin
            op = `OP_ILLEGAL;
            next_state = ST_UNINIT;
          end
        end
      end
      default: next_state = ST_UNINIT;
    endcase
    // a drop of enable mid-burst forces the next state to ST_UNINIT on the clock edge
    if (cke_prev && !cke_now && burst_busy) begin
      next_state = ST_UNINIT;
    end
  end

  bank_state_mem #(.BANKS(BANKS), .BA_W(BA_W)) u_banks (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clr_all(op == `OP_PREALL || next_state == ST_UNINIT),
    .set_en(op == `OP_ACT),
    .clr_en(op == `OP_PRE || op == `OP_RDA || op == `OP_WRA),
    .bank(ba),
    .any_open(any_open)
  );

  // ------------------------------------------------------------
  // state, burst counter and outputs
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_UNINIT;
      burst_cnt <= 4'h0;
      cmd_op <= `OP_NONE;
      cmd_valid <= 1'b0;
      cmd_bank <= {BA_W{1'b0}};
      cmd_addr <= {ADDR_W{1'b0}};
      cmd_auto_pre <= 1'b0;
      cmd_all_banks <= 1'b0;
      wr_beat_en <= 1'b0;
      burst_busy <= 1'b0;
      active_pd <= 1'b0;
      precharge_pd <= 1'b0;
      self_refresh <= 1'b0;
      odt_en <= 1'b0;
      ready <= 1'b0;
      contents_lost <= 1'b0;
      illegal_seen <= 1'b0;
    end else begin
      state <= next_state;
      cmd_op <= op;
      cmd_valid <= (op != `OP_NONE);
      cmd_bank <= ba;
      cmd_addr <= addr;
      cmd_auto_pre <= (op == `OP_RDA || op == `OP_WRA);
      cmd_all_banks <= (op == `OP_PREALL);
      // bursts of four beats run their two clocks to the end
      if (op == `OP_RD || op == `OP_RDA || op == `OP_WR || op == `OP_WRA) begin
        burst_cnt <= `BURST_CLOCKS;
      end else if (burst_cnt != 4'h0) begin
        burst_cnt <= burst_cnt - 4'h1;
      end
      burst_busy <= (op == `OP_RD || op == `OP_RDA || op == `OP_WR || op == `OP_WRA) ||
                    (burst_cnt > 4'h1);
      // mask sampled with its beat: low writes, high skips
      wr_beat_en <= burst_busy && !dm;
      active_pd <= (next_state == ST_APD);
      precharge_pd <= (next_state == ST_PPD);
      self_refresh <= (next_state == ST_SREF);
      odt_en <= odt && (next_state != ST_SREF) && (next_state != ST_UNINIT);
      ready <= (next_state == ST_RUN);
      // sticky until init completes; loss flag set wins over init clear
      if (cke_prev && !cke_now && burst_busy) begin
        contents_lost <= 1'b1;
      end else if (state == ST_UNINIT && next_state == ST_RUN) begin
        contents_lost <= 1'b0;
      end
      if (op == `OP_ILLEGAL) begin
        illegal_seen <= 1'b1;
      end else if (state == ST_UNINIT && next_state == ST_RUN) begin
        illegal_seen <= 1'b0;
      end
    end
  end
endmodule // ddr2_command_cke_decoder

/* include/ddr2_cmd_consts.vh */
`ifndef DDR2_CMD_CONSTS_VH
`define DDR2_CMD_CONSTS_VH
// command codes {ras_n, cas_n, we_n}
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ACT 3'h3
`define CMD_WR 3'h4
`define CMD_RD 3'h5
`define CMD_NOP 3'h7
// decoded command ids
`define OP_NONE 4'h0
`define OP_MRS 4'h1
`define OP_REF 4'h2
`define OP_PRE 4'h3
`define OP_PREALL 4'h4
`define OP_ACT 4'h5
`define OP_WR 4'h6
`define OP_WRA 4'h7
`define OP_RD 4'h8
`define OP_RDA 4'h9
`define OP_SREF_IN 4'ha
`define OP_PD_IN 4'hb
`define OP_EXIT 4'hc
`define OP_ILLEGAL 4'hf
// burst length 4 beats, two clocks of double rate data
`define BURST_CLOCKS 4'h2
// ras_n bit position in the command code
`define CMD_RAS_BIT 2
`endif
